// file: design/aasr_pkg.sv
/*
 * Package for the autostart serial readout block: frame length, timing
 * constants and state encodings.
 * Assumes a 200 MHz system clock; nothing else.
 */
package aasr_pkg;
   // System clock period in picoseconds.
   localparam int unsigned CLK_PERIOD_PS    = 5000;
   // Internal serial clock half period in nanoseconds.
   localparam int unsigned SCK_HALF_NS      = 40;
   // Half period in system clock cycles, rounded down, at least one.
   localparam int unsigned SCK_HALF_CYC     =
      (SCK_HALF_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 :
      (SCK_HALF_NS * 1000 / CLK_PERIOD_PS);
   // Rising serial clock edges in one output frame.
   localparam int unsigned FRAME_EDGES      = 24;
   // Result width shifted after the leading done bit.
   localparam int unsigned RESULT_W         = 23;
   // Default conversion length in system cycles.
   localparam int unsigned CONV_CYC_DEF     = 64;
   // Default sleep length standing in for the timing capacitor.
   localparam int unsigned SLEEP_CYC_DEF    = 32;
   // Sequencer states.
   typedef enum logic [2:0] {
      AASR_CONV  = 3'b000,
      AASR_SLEEP = 3'b001,
      AASR_LOW   = 3'b010,
      AASR_HIGH  = 3'b011
   } aasr_state_t;
endpackage : aasr_pkg

// file: design/aasr_fifo_if.sv
/*
 * Interface carrying a valid/ready word stream between modules.
 * Assumes producer and consumer share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface aasr_fifo_if #(parameter int W = 23);
   logic         valid;  // Word offered.
   logic         ready;  // Word accepted.
   logic [W-1:0] data;   // Word payload.
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : aasr_fifo_if
`default_nettype wire

// file: design/aasr_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module aasr_fifo #(
   parameter int W     = 23,
   parameter int DEPTH = 4
) (
   input  wire logic clk,
   input  wire logic rst_b,
   aasr_fifo_if.dst  wr,
   aasr_fifo_if.src  rd
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];      // Word storage.
   logic [AW:0]  cnt_r, cnt_nxt;   // Fill level.
   logic [AW-1:0] wp_r, wp_nxt;    // Write pointer.
   logic [AW-1:0] rp_r, rp_nxt;    // Read pointer.
   logic push;                     // Write accepted.
   logic pop;                      // Read accepted.

   // Honest full and empty drive the handshakes.
   assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
   assign rd.valid = (cnt_r != '0);
   assign rd.data  = mem[rp_r];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   // Pointer and level updates.
   always_comb begin
      wp_nxt  = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
      rp_nxt  = pop  ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Registers only.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         wp_r  <= '0;
         rp_r  <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
      end
   end

   // Storage write, no reset needed on data.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= wr.data;
      end
   end
endmodule : aasr_fifo
`default_nettype wire

// file: design/aasr_top.sv
/*
 * Autostart serial readout sequencer: converts, sleeps on a timer that
 * models the chip-select capacitor, then drives a 24-edge serial frame.
 * Assumes results arrive on a valid/ready port in this clock domain and
 * that the serial clock pin is sampled from outside through two flops.
 */
// Summary of operation
// - Chip select held high during conversion.
// - Conversion end enters sleep, starts discharge.
// - Threshold crossing starts output without host.
// - Frame spans exactly 24 rising edges.
// - Data changes on falling serial edges.
// - Device drives its own serial clock.
// - After edge 24 and its high half period, restart conversion.
// - Threshold crossing picks clock mode from the pulled-up clock pin.
// - Clock pin pulled up while discharging.
// - Outputs high converting, low when done.
// - Sleep at least half serial period.
// - Host samples done bit edge 1.
`timescale 1ns/1ps
`default_nettype none
module aasr_top
   import aasr_pkg::*;
#(
   parameter int unsigned CONV_CYC  = aasr_pkg::CONV_CYC_DEF,
   parameter int unsigned SLEEP_CYC = aasr_pkg::SLEEP_CYC_DEF,
   parameter int unsigned FIFO_DEPTH = 4
) (
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   input  wire logic                         res_valid,
   output logic                              res_ready,
   input  wire logic [aasr_pkg::RESULT_W-1:0] res_data,
   output logic                              conv_busy,
   output logic                              cs_pullup_en,
   output logic                              cs_sink_en,
   output logic                              sck_o,
   output logic                              sck_oe,
   input  wire logic                         sck_i,
   output logic                              sck_pullup_en,
   output logic                              sdo_o,
   output logic                              sdo_oe,
   output logic                              int_sck_mode
);
   import aasr_pkg::*;

   aasr_fifo_if #(.W(RESULT_W)) in_if ();   // Producer to FIFO.
   aasr_fifo_if #(.W(RESULT_W)) out_if ();  // FIFO to shifter.

   assign in_if.valid = res_valid;
   assign in_if.data  = res_data;
   assign res_ready   = in_if.ready;

   // Result buffer between converter core and shifter.
   aasr_fifo #(.W(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk   (clk),
      .rst_b (rst_b),
      .wr    (in_if),
      .rd    (out_if)
   );

   aasr_state_t       st_r, st_nxt;        // Sequencer state.
   logic [31:0]       tmr_r, tmr_nxt;      // Conversion/sleep/half timer.
   logic [4:0]        edg_r, edg_nxt;      // Rising edges issued.
   logic [RESULT_W:0] shf_r, shf_nxt;      // Done bit plus result.
   logic              sck_r, sck_nxt;      // Serial clock level.
   logic              sdo_r, sdo_nxt;      // Serial data level.
   logic              mode_r, mode_nxt;    // Internal clock mode chosen.
   logic              sck_s1_r, sck_s2_r;  // Clock pin synchroniser.
   logic              thr_cross;           // Modelled threshold crossing.

   // The clock pin comes from outside, so two flops before use.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sck_s1_r <= 1'b1;
         sck_s2_r <= 1'b1;
      end else begin
         sck_s1_r <= sck_i;
         sck_s2_r <= sck_s1_r;
      end
   end

   // Sleep timer expiry stands in for the capacitor voltage crossing.
   assign thr_cross = (st_r == AASR_SLEEP)
                   && (tmr_r == 32'h0000_0000);

   // Next-state logic for the whole sequencer.
   always_comb begin
      st_nxt   = st_r;
      tmr_nxt  = tmr_r;
      edg_nxt  = edg_r;
      shf_nxt  = shf_r;
      sck_nxt  = sck_r;
      sdo_nxt  = sdo_r;
      mode_nxt = mode_r;
      out_if.ready = 1'b0;
      unique case (st_r)
         AASR_CONV: begin
            // Conversion ends once time is up and a result waits.
            if (tmr_r != 32'h0000_0000) begin
               tmr_nxt = tmr_r - 32'h0000_0001;
            end else if (out_if.valid) begin
               out_if.ready = 1'b1;
               shf_nxt = {1'b0, out_if.data};
               sck_nxt = 1'b0;
               sdo_nxt = 1'b0;
               // Sleep never shorter than half a serial period.
               tmr_nxt = (SLEEP_CYC > SCK_HALF_CYC) ?
                         32'(SLEEP_CYC) : 32'(SCK_HALF_CYC);
               st_nxt  = AASR_SLEEP;
            end
         end
         AASR_SLEEP: begin
            if (!thr_cross) begin
               tmr_nxt = tmr_r - 32'h0000_0001;
            end else begin
               // Mode picked from the pulled-up clock pin.
               mode_nxt = sck_s2_r;
               edg_nxt  = 5'h00;
               tmr_nxt  = 32'(SCK_HALF_CYC - 1);
               st_nxt   = AASR_LOW;
            end
         end
         AASR_LOW: begin
            if (tmr_r != 32'h0000_0000) begin
               tmr_nxt = tmr_r - 32'h0000_0001;
            end else begin
               sck_nxt = 1'b1;
               edg_nxt = edg_r + 5'h01;
               tmr_nxt = 32'(SCK_HALF_CYC - 1);
               st_nxt  = AASR_HIGH;
            end
         end
         AASR_HIGH: begin
            if (tmr_r != 32'h0000_0000) begin
               tmr_nxt = tmr_r - 32'h0000_0001;
            end else if (edg_r == 5'(FRAME_EDGES)) begin
               // Frame over: both lines high, new conversion.
               sdo_nxt = 1'b1;
               tmr_nxt = 32'(CONV_CYC);
               st_nxt  = AASR_CONV;
            end else begin
               sck_nxt = 1'b0;
               sdo_nxt = shf_r[RESULT_W-1];
               shf_nxt = {shf_r[RESULT_W-1:0], 1'b0};
               tmr_nxt = 32'(SCK_HALF_CYC - 1);
               st_nxt  = AASR_LOW;
            end
         end
         default: begin
            st_nxt = AASR_CONV;
         end
      endcase
   end

   // Registers only; conversion starts out of reset.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r   <= AASR_CONV;
         tmr_r  <= 32'(CONV_CYC_DEF);
         edg_r  <= 5'h00;
         shf_r  <= '0;
         sck_r  <= 1'b1;
         sdo_r  <= 1'b1;
         mode_r <= 1'b1;
      end else begin
         st_r   <= st_nxt;
         tmr_r  <= tmr_nxt;
         edg_r  <= edg_nxt;
         shf_r  <= shf_nxt;
         sck_r  <= sck_nxt;
         sdo_r  <= sdo_nxt;
         mode_r <= mode_nxt;
      end
   end

   // Pin controls follow the state.
   assign conv_busy     = (st_r == AASR_CONV);
   assign cs_pullup_en  = (st_r != AASR_SLEEP);
   assign cs_sink_en    = (st_r == AASR_SLEEP);
   assign sck_pullup_en = (st_r == AASR_SLEEP);
   assign sck_o         = sck_r;
   assign sck_oe        = (st_r != AASR_SLEEP);
   assign sdo_o         = sdo_r;
   assign sdo_oe        = 1'b1;
   assign int_sck_mode  = mode_r;

   // Frame edges counted over a whole frame.
   sequence frame_open_s;
      $rose(sck_r) && (edg_r == 5'h01);
   endsequence
   sequence frame_close_s;
      (st_r == AASR_HIGH) && (edg_r == 5'(FRAME_EDGES)) && (tmr_r == 0);
   endsequence

   frame_edges_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(sck_r) |-> (edg_r >= 5'h01) && (edg_r <= 5'(FRAME_EDGES)))
      else $error("serial clock edge beyond frame length");
   restart_conv_a: assert property (@(posedge clk) disable iff (!rst_b)
      frame_close_s |=> (st_r == AASR_CONV) && sdo_r && sck_r)
      else $error("conversion not restarted after last edge");
   conv_high_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_r == AASR_CONV) |-> sck_r && sdo_r && cs_pullup_en)
      else $error("lines not high during conversion");
   done_low_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_r == AASR_CONV) ##1 (st_r == AASR_SLEEP) |-> !sck_r && !sdo_r)
      else $error("done indication not low at sleep entry");
   sleep_min_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(st_r == AASR_SLEEP) |-> (st_r == AASR_SLEEP) [*8])
      else $error("sleep shorter than half serial period");
   autostart_a: assert property (@(posedge clk) disable iff (!rst_b)
      thr_cross |=> (st_r == AASR_LOW))
      else $error("output did not start at threshold");
   data_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
      $changed(sdo_r) && (st_r != AASR_CONV) && !$past(st_r == AASR_CONV)
      |-> !sck_r)
      else $error("data changed while clock high");
   mode_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
      thr_cross |=> (mode_r == $past(sck_s2_r)))
      else $error("clock mode not reselected at threshold");
   pullup_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_r == AASR_SLEEP) |-> sck_pullup_en && !sck_oe && cs_sink_en)
      else $error("clock pull-up missing while discharging");
   first_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
      frame_open_s |-> sck_oe && (sdo_r == 1'b0))
      else $error("first edge without done bit driven");
endmodule : aasr_top
`default_nettype wire

// file: tb/aasr_host_model.sv
/* Behavioural host that receives the serial result frame.
   Assumes the device drives the serial clock and data lines while it
   is not sleeping, and that a weak pull-up holds the clock otherwise. */
`timescale 1ns/1ps
`default_nettype none
module aasr_host_model (
   input  wire logic   rst_b,
   input  wire logic   sck_o,
   input  wire logic   sck_oe,
   input  wire logic   sck_pullup_en,
   input  wire logic   sdo_o,
   input  wire logic   sdo_oe,
   input  wire logic   drag_low,
   output logic        sck_wire,
   output logic [23:0] frame_word,
   output int          frame_cnt
);
   logic [23:0] shift_r;  // Bits gathered so far in this frame.
   int          edges_r;  // Rising edges counted in this frame.
   // Nothing has been received before the first frame.
   initial begin
      edges_r = 0;
      frame_cnt = 0;
      frame_word = 24'h0;
      shift_r = 24'h0;
   end
   // Resolves the clock wire: device drive first, then the host.
   always_comb begin
      if (sck_oe === 1'b1) sck_wire = sck_o;
      else if (drag_low) sck_wire = 1'b0;
      else sck_wire = (sck_pullup_en === 1'b1);
   end
   // Takes one bit on each rising edge that the device drives. The
   // driven level is watched rather than the resolved wire, so that a
   // zero-time glitch at sleep entry or the reset edge adds no bit.
   always @(posedge sck_o) begin
      if (sck_oe === 1'b1 && rst_b === 1'b1) begin
         shift_r = {shift_r[22:0], sdo_oe ? sdo_o : 1'b1};
         edges_r++;
         if (edges_r == 24) begin
            frame_word = shift_r;
            frame_cnt++;
            edges_r = 0;
         end
      end
   end
endmodule : aasr_host_model
`default_nettype wire

// file: tb/tb.sv
/* Self-checking testbench for the autostart serial readout block.
   Assumes the host model and shortened conversion and sleep counts. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import aasr_pkg::*;
   logic                clk = 1'b0;       // System clock.
   logic                rst_b = 1'b0;     // Reset, active low.
   logic                res_valid = 1'b0; // Result word offered.
   logic [RESULT_W-1:0] res_data = 23'h0; // Result word.
   logic                drag_low = 1'b0;  // Host drags the clock low.
   logic res_ready, conv_busy, cs_pullup_en, cs_sink_en, sck_o, sck_oe;
   logic sck_i, sck_pullup_en, sdo_o, sdo_oe, int_sck_mode;
   logic [23:0]         frame_word;       // Last frame received.
   int                  frame_cnt;        // Frames received.
   int                  fails = 0;        // Mismatches.
   int                  checked = 0;      // Comparisons made.
   // Clock of 5 ns period.
   always #2.5 clk = ~clk;
   aasr_top #(.CONV_CYC(16), .SLEEP_CYC(8)) DUT (.clk(clk), .rst_b(rst_b),
      .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
      .conv_busy(conv_busy), .cs_pullup_en(cs_pullup_en),
      .cs_sink_en(cs_sink_en), .sck_o(sck_o), .sck_oe(sck_oe),
      .sck_i(sck_i), .sck_pullup_en(sck_pullup_en), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe), .int_sck_mode(int_sck_mode));
   aasr_host_model host (.rst_b(rst_b), .sck_o(sck_o), .sck_oe(sck_oe),
      .sck_pullup_en(sck_pullup_en), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
      .drag_low(drag_low), .sck_wire(sck_i), .frame_word(frame_word),
      .frame_cnt(frame_cnt));
   // Compares one value and counts it.
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Prints the verdict and ends the run.
   task automatic print_verdict();
      if (fails == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   // Ends the run when a wait runs out.
   task automatic give_up();
      fails++;
      $display("[ERR] %0t wait ran out", $time);
      print_verdict();
   endtask : give_up
   // Offers one word for up to three cycles; ok tells if it was taken.
   task automatic push(input logic [22:0] d, output logic ok);
      logic r;
      ok = 1'b0;
      @(posedge clk);
      res_valid <= 1'b1;
      res_data <= d;
      for (int i = 0; i < 3 && !ok; i++) begin
         @(negedge clk);
         r = res_ready;
         @(posedge clk);
         ok = (r === 1'b1);
      end
      res_valid <= 1'b0;
   endtask : push
   // Waits until the conversion ends, within a bound.
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (conv_busy !== 1'b0 && n < 500);
      if (n >= 500) give_up();
   endtask : wait_done
   // Follows one whole cycle of sleep, frame and restart for word d.
   task automatic wait_frame(input logic [22:0] d);
      int n;
      int f0;
      f0 = frame_cnt;
      wait_done();
      check({sck_o, sdo_o}, 24'h0);
      check({cs_sink_en, cs_pullup_en, sck_oe, sck_pullup_en},
            24'h9);
      n = 0;
      while (sck_oe !== 1'b1 && n < 500) begin
         @(negedge clk);
         n++;
      end
      if (n >= 500) give_up();
      check(n >= SCK_HALF_CYC, 24'h1);
      check(int_sck_mode, 24'h1);
      n = 0;
      while (frame_cnt == f0 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 1000) give_up();
      check(frame_word, {1'b0, d});
      check(sck_oe, 24'h1);
      n = 0;
      while (conv_busy !== 1'b1 && n < 12) begin
         @(negedge clk);
         n++;
      end
      if (n >= 12) give_up();
      check({sck_o, sdo_o, cs_pullup_en, cs_sink_en},
            24'he);
   endtask : wait_frame
   // Outputs right after reset show a conversion in progress.
   task automatic test_reset();
      repeat (2) @(negedge clk);
      check({conv_busy, sck_o, sdo_o, cs_pullup_en, cs_sink_en,
             int_sck_mode, sck_oe, sdo_oe}, 24'hf7);
   endtask : test_reset
   // Fills the buffer until it refuses, then drains it frame by frame.
   task automatic test_fill();
      logic [22:0] w [5];
      logic        ok;
      int          taken;
      w = '{23'h7fffff, 23'h000001, 23'h400000, 23'h2aaaaa, 23'h155555};
      taken = 0;
      for (int i = 0; i < 5; i++) begin
         push(w[i], ok);
         taken += ok;
      end
      check(taken, 24'h4);
      for (int i = 0; i < 4; i++) begin
         wait_frame(w[i]);
         check(res_ready, 24'h1);
      end
   endtask : test_fill
   // The host drags the clock low in sleep: internal mode is dropped.
   task automatic test_drag();
      logic ok;
      push(23'h123456, ok);
      wait_done();
      @(posedge clk);
      drag_low <= 1'b1;
      repeat (40) @(negedge clk);
      check(int_sck_mode, 24'h0);
      @(posedge clk);
      drag_low <= 1'b0;
   endtask : test_drag
   // Main sequence.
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      test_reset();
      test_fill();
      test_drag();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
